// ### camd_pkg.sv
package camd_pkg;

  typedef enum logic [2:0] {
    MODE_INH = 3'h0,
    MODE_IMM = 3'h1,
    MODE_DIR = 3'h2,
    MODE_EXT = 3'h3,
    MODE_IX = 3'h4,
    MODE_IX1 = 3'h5,
    MODE_IX2 = 3'h6,
    MODE_REL = 3'h7
  } camd_mode_t;

  typedef enum logic [2:0] {
    CLS_REGMEM = 3'h0,
    CLS_RMW = 3'h1,
    CLS_BRANCH = 3'h2,
    CLS_BITTEST = 3'h3,
    CLS_BITMANIP = 3'h4,
    CLS_JUMP = 3'h5,
    CLS_CONTROL = 3'h6
  } camd_class_t;

  // Opcode high nibble rows
  localparam logic [3:0] ROW_BITTEST = 4'h0;
  localparam logic [3:0] ROW_BITMANIP = 4'h1;
  localparam logic [3:0] ROW_REL = 4'h2;
  localparam logic [3:0] ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] ROW_RMW_A = 4'h4;
  localparam logic [3:0] ROW_RMW_X = 4'h5;
  localparam logic [3:0] ROW_RMW_IX1 = 4'h6;
  localparam logic [3:0] ROW_RMW_IX = 4'h7;
  localparam logic [3:0] ROW_CTRL_A = 4'h8;
  localparam logic [3:0] ROW_CTRL_B = 4'h9;
  localparam logic [3:0] ROW_IMM = 4'hA;
  localparam logic [3:0] ROW_DIR = 4'hB;
  localparam logic [3:0] ROW_EXT = 4'hC;
  localparam logic [3:0] ROW_IX2 = 4'hD;
  localparam logic [3:0] ROW_IX1 = 4'hE;
  localparam logic [3:0] ROW_IX = 4'hF;

  // Opcode low nibbles and whole opcodes
  localparam logic [3:0] NIB_TST = 4'hD;
  localparam logic [3:0] NIB_JMP = 4'hC;
  localparam logic [3:0] NIB_JSR = 4'hD;
  localparam logic [3:0] NIB_CPX = 4'h3;
  localparam logic [3:0] NIB_LDX = 4'hE;
  localparam logic [3:0] NIB_STX = 4'hF;
  localparam logic [7:0] OP_BSR = 8'hAD;

  // Relative branch condition pairs, indexed by opcode bits 3..1
  localparam logic [2:0] COND_ALWAYS = 3'h0;
  localparam logic [2:0] COND_HIGHER = 3'h1;
  localparam logic [2:0] COND_CARRY_CLR = 3'h2;
  localparam logic [2:0] COND_NOT_EQUAL = 3'h3;
  localparam logic [2:0] COND_HCARRY_CLR = 3'h4;
  localparam logic [2:0] COND_PLUS = 3'h5;
  localparam logic [2:0] COND_MASK_CLR = 3'h6;
  localparam logic [2:0] COND_IRQ_LOW = 3'h7;

  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] IDX_FIRST = 2'h0;
  localparam logic [1:0] IDX_SECOND = 2'h1;
  localparam logic [1:0] IDX_STEP = 2'h1;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] IX1_TOP = 16'h01FE;
  localparam logic [15:0] RESET_PC = 16'h0000;

endpackage : camd_pkg

// ### camd_classify.sv
`timescale 1ns/1ns
`default_nettype none
module camd_classify (
  input wire logic [7:0] opcode,
  output camd_pkg::camd_mode_t mode,
  output camd_pkg::camd_class_t cls,
  output logic [1:0] len,
  output logic writeback,
  output logic reg_x,
  output logic [2:0] bitnum,
  output logic bit_on_set
);
  logic [3:0] row;
  logic [3:0] nib;
  assign row = opcode[7:4];
  assign nib = opcode[3:0];
  assign bitnum = opcode[3:1]; // RULE10
  assign bit_on_set = ~opcode[0]; // RULE10

  always_comb begin
    mode = camd_pkg::MODE_INH;
    cls = camd_pkg::CLS_CONTROL;
    len = camd_pkg::LEN_1;
    writeback = 1'b0;
    reg_x = 1'b0;
    unique case (row)
      camd_pkg::ROW_BITTEST: begin
        mode = camd_pkg::MODE_DIR; // RULE9
        cls = camd_pkg::CLS_BITTEST;
        len = camd_pkg::LEN_3;
      end
      camd_pkg::ROW_BITMANIP: begin
        mode = camd_pkg::MODE_DIR;
        cls = camd_pkg::CLS_BITMANIP;
        len = camd_pkg::LEN_2;
        writeback = 1'b1; // RULE11
      end
      camd_pkg::ROW_REL: begin
        mode = camd_pkg::MODE_REL; // RULE13
        cls = camd_pkg::CLS_BRANCH;
        len = camd_pkg::LEN_2;
      end
      camd_pkg::ROW_RMW_DIR, camd_pkg::ROW_RMW_A, camd_pkg::ROW_RMW_X,
      camd_pkg::ROW_RMW_IX1, camd_pkg::ROW_RMW_IX: begin
        cls = camd_pkg::CLS_RMW;
        writeback = (nib != camd_pkg::NIB_TST); // RULE11
        reg_x = (row == camd_pkg::ROW_RMW_X);
        if (row == camd_pkg::ROW_RMW_DIR) begin
          mode = camd_pkg::MODE_DIR;
          len = camd_pkg::LEN_2;
        end else if (row == camd_pkg::ROW_RMW_IX1) begin
          mode = camd_pkg::MODE_IX1;
          len = camd_pkg::LEN_2;
        end else if (row == camd_pkg::ROW_RMW_IX) begin
          mode = camd_pkg::MODE_IX;
        end
      end
      camd_pkg::ROW_CTRL_A, camd_pkg::ROW_CTRL_B: begin
        cls = camd_pkg::CLS_CONTROL; // RULE1
      end
      default: begin
        cls = camd_pkg::CLS_REGMEM; // RULE12
        reg_x = (nib == camd_pkg::NIB_CPX) || (nib == camd_pkg::NIB_LDX)
          || (nib == camd_pkg::NIB_STX);
        if ((nib == camd_pkg::NIB_JMP) || (nib == camd_pkg::NIB_JSR)) begin
          cls = camd_pkg::CLS_JUMP; // RULE13
          reg_x = 1'b0;
        end
        unique case (row)
          camd_pkg::ROW_IMM: begin
            mode = camd_pkg::MODE_IMM; // RULE2
            len = camd_pkg::LEN_2;
          end
          camd_pkg::ROW_DIR: begin
            mode = camd_pkg::MODE_DIR;
            len = camd_pkg::LEN_2;
          end
          camd_pkg::ROW_EXT: begin
            mode = camd_pkg::MODE_EXT; // RULE4
            len = camd_pkg::LEN_3;
          end
          camd_pkg::ROW_IX2: begin
            mode = camd_pkg::MODE_IX2; // RULE7
            len = camd_pkg::LEN_3;
          end
          camd_pkg::ROW_IX1: begin
            mode = camd_pkg::MODE_IX1; // RULE6
            len = camd_pkg::LEN_2;
          end
          default: begin
            mode = camd_pkg::MODE_IX; // RULE5
          end
        endcase
        if (opcode == camd_pkg::OP_BSR) begin
          mode = camd_pkg::MODE_REL; // RULE13
          cls = camd_pkg::CLS_BRANCH;
          reg_x = 1'b0;
        end
      end
    endcase
  end
endmodule : camd_classify
`default_nettype wire

// ### camd_decode.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE1: Inherent opcodes are one byte, no operand, no memory address.
// RULE2: Immediate is two bytes; second byte is the operand itself.
// RULE3: Direct uses one byte as low address, high byte zero.
// RULE4: Extended fetches high then low address byte, full 16-bit address.
// RULE5: Indexed no offset: address is index register with zero high byte.
// RULE6: Indexed 8-bit offset: unsigned index plus byte, sum not wrapped.
// RULE7: Indexed 16-bit offset: high then low offset plus unsigned index.
// RULE8: Taken branch adds signed offset to next address; else falls through.
// RULE9: Bit test branch is three bytes; tested bit goes to carry.
// RULE10: Bit number and set/clear sense come from the opcode.
// RULE11: Read-modify-write writes back, except test negative or zero.
// RULE12: Register/memory ops pair accumulator or index with memory operand.
// RULE13: Branches are relative; jumps give an effective address only.
// RULE14: Branches exist on interrupt pin level high and low.
// RULE15: Branches exist on interrupt mask and half-carry, clear and set.
// RULE16: Bytes fetched at rising addresses; PC passes instruction before target.
module camd_decode (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic [7:0] index_reg,
  input wire logic ccr_h,
  input wire logic ccr_i,
  input wire logic ccr_n,
  input wire logic ccr_z,
  input wire logic ccr_c,
  input wire logic irq_pin_level,
  input wire logic exec_done,
  input wire logic exec_pc_load,
  input wire logic [15:0] exec_pc_value,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  output logic dec_valid,
  output logic [7:0] dec_opcode,
  output camd_pkg::camd_mode_t dec_mode,
  output camd_pkg::camd_class_t dec_class,
  output logic [1:0] dec_len,
  output logic [15:0] dec_ea,
  output logic [7:0] dec_imm,
  output logic [2:0] dec_bitnum,
  output logic dec_bit_on_set,
  output logic dec_writeback,
  output logic dec_reg_x,
  output logic dec_taken,
  output logic dec_carry_load,
  output logic dec_carry_value,
  output logic [15:0] dec_pc_seq,
  output logic [15:0] pc_next
);
  typedef enum logic [1:0] {
    ST_REQ = 2'h0,
    ST_WAIT = 2'h1,
    ST_CALC = 2'h2,
    ST_DONE = 2'h3
  } camd_state_t;

  camd_state_t state, next_state;
  logic [15:0] pc, next_pc, op_addr, next_op_addr;
  logic [1:0] idx, next_idx;
  logic opnd_phase, next_opnd_phase;
  logic [7:0] opcode, next_opcode, b1, next_b1, b2, next_b2, operand, next_operand;
  logic next_mem_rd, next_dec_valid, next_dec_taken, next_dec_carry_value;
  logic [15:0] next_mem_addr, next_dec_ea, next_pc_next;
  logic [7:0] cur_op, rel;
  logic [15:0] target;
  logic base_cond, tested_bit;
  camd_pkg::camd_mode_t c_mode;
  camd_pkg::camd_class_t c_cls;
  logic [1:0] c_len;
  logic c_wb, c_reg_x, c_on_set;
  logic [2:0] c_bitnum;

  assign cur_op = (state == ST_WAIT && idx == camd_pkg::IDX_FIRST) ? mem_rdata : opcode;

  camd_classify camd_classify_inst (
    .opcode(cur_op),
    .mode(c_mode),
    .cls(c_cls),
    .len(c_len),
    .writeback(c_wb),
    .reg_x(c_reg_x),
    .bitnum(c_bitnum),
    .bit_on_set(c_on_set)
  );

  assign rel = (c_cls == camd_pkg::CLS_BITTEST) ? b2 : b1;
  assign target = pc + {{8{rel[7]}}, rel}; // RULE8 RULE16
  assign tested_bit = operand[c_bitnum]; // RULE9

  always_comb begin
    unique case (opcode[3:1])
      camd_pkg::COND_ALWAYS: base_cond = 1'b1;
      camd_pkg::COND_HIGHER: base_cond = ~(ccr_c | ccr_z);
      camd_pkg::COND_CARRY_CLR: base_cond = ~ccr_c;
      camd_pkg::COND_NOT_EQUAL: base_cond = ~ccr_z;
      camd_pkg::COND_HCARRY_CLR: base_cond = ~ccr_h; // RULE15
      camd_pkg::COND_PLUS: base_cond = ~ccr_n;
      camd_pkg::COND_MASK_CLR: base_cond = ~ccr_i; // RULE15
      camd_pkg::COND_IRQ_LOW: base_cond = ~irq_pin_level; // RULE14
    endcase
  end

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_op_addr = op_addr;
    next_idx = idx;
    next_opnd_phase = opnd_phase;
    next_opcode = opcode;
    next_b1 = b1;
    next_b2 = b2;
    next_operand = operand;
    next_mem_rd = 1'b0;
    next_mem_addr = mem_addr;
    next_dec_valid = 1'b0;
    next_dec_ea = dec_ea;
    next_dec_taken = dec_taken;
    next_dec_carry_value = dec_carry_value;
    next_pc_next = pc_next;
    unique case (state)
      ST_REQ: begin
        next_mem_rd = 1'b1;
        next_mem_addr = opnd_phase ? {camd_pkg::PAGE_ZERO, b1} : pc; // RULE9 RULE16
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (mem_rvalid) begin
          if (opnd_phase) begin
            next_operand = mem_rdata;
            next_state = ST_CALC;
          end else begin
            next_pc = pc + camd_pkg::PC_STEP; // RULE16
            if (idx == camd_pkg::IDX_FIRST) begin
              next_opcode = mem_rdata;
              next_op_addr = pc;
            end else if (idx == camd_pkg::IDX_SECOND) begin
              next_b1 = mem_rdata;
            end else begin
              next_b2 = mem_rdata;
            end
            if (idx + camd_pkg::IDX_STEP < c_len) begin
              next_idx = idx + camd_pkg::IDX_STEP;
              next_state = ST_REQ;
            end else if (c_cls == camd_pkg::CLS_BITTEST) begin
              next_opnd_phase = 1'b1;
              next_state = ST_REQ;
            end else begin
              next_state = ST_CALC;
            end
          end
        end
      end
      ST_CALC: begin
        next_dec_valid = 1'b1;
        next_dec_taken = 1'b0;
        next_dec_carry_value = 1'b0;
        unique case (c_mode)
          camd_pkg::MODE_DIR: next_dec_ea = {camd_pkg::PAGE_ZERO, b1}; // RULE3
          camd_pkg::MODE_EXT: next_dec_ea = {b1, b2}; // RULE4
          camd_pkg::MODE_IX: next_dec_ea = {camd_pkg::PAGE_ZERO, index_reg}; // RULE5
          camd_pkg::MODE_IX1:
            next_dec_ea = {camd_pkg::PAGE_ZERO, index_reg} + {camd_pkg::PAGE_ZERO, b1}; // RULE6
          camd_pkg::MODE_IX2: next_dec_ea = {b1, b2} + {camd_pkg::PAGE_ZERO, index_reg}; // RULE7
          camd_pkg::MODE_REL: next_dec_ea = target; // RULE8
          default: next_dec_ea = {camd_pkg::PAGE_ZERO, camd_pkg::PAGE_ZERO}; // RULE1 RULE2
        endcase
        if (c_cls == camd_pkg::CLS_BITTEST) begin
          next_dec_carry_value = tested_bit; // RULE9
          next_dec_taken = (tested_bit == c_on_set); // RULE9 RULE10
          next_dec_ea = {camd_pkg::PAGE_ZERO, b1};
        end else if (c_cls == camd_pkg::CLS_BRANCH) begin
          next_dec_taken = (opcode == camd_pkg::OP_BSR) || (base_cond ^ opcode[0]); // RULE8
        end
        next_pc_next = next_dec_taken ? target : pc; // RULE8
        next_pc = next_pc_next;
        next_state = ST_DONE;
      end
      ST_DONE: begin
        if (exec_done) begin
          if (exec_pc_load) begin
            next_pc = exec_pc_value; // RULE13
          end
          next_idx = camd_pkg::IDX_FIRST;
          next_opnd_phase = 1'b0;
          next_state = ST_REQ;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_REQ;
      pc <= camd_pkg::RESET_PC;
      op_addr <= camd_pkg::RESET_PC;
      idx <= camd_pkg::IDX_FIRST;
      opnd_phase <= 1'b0;
      opcode <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      operand <= 8'h00;
      mem_rd <= 1'b0;
      mem_addr <= camd_pkg::RESET_PC;
      dec_valid <= 1'b0;
      dec_ea <= 16'h0000;
      dec_taken <= 1'b0;
      dec_carry_value <= 1'b0;
      pc_next <= camd_pkg::RESET_PC;
    end else begin
      state <= next_state;
      pc <= next_pc;
      op_addr <= next_op_addr;
      idx <= next_idx;
      opnd_phase <= next_opnd_phase;
      opcode <= next_opcode;
      b1 <= next_b1;
      b2 <= next_b2;
      operand <= next_operand;
      mem_rd <= next_mem_rd;
      mem_addr <= next_mem_addr;
      dec_valid <= next_dec_valid;
      dec_ea <= next_dec_ea;
      dec_taken <= next_dec_taken;
      dec_carry_value <= next_dec_carry_value;
      pc_next <= next_pc_next;
    end
  end

  // Decode fields captured with the result
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dec_opcode <= 8'h00;
      dec_mode <= camd_pkg::MODE_INH;
      dec_class <= camd_pkg::CLS_CONTROL;
      dec_len <= camd_pkg::LEN_1;
      dec_imm <= 8'h00;
      dec_bitnum <= 3'h0;
      dec_bit_on_set <= 1'b0;
      dec_writeback <= 1'b0;
      dec_reg_x <= 1'b0;
      dec_carry_load <= 1'b0;
      dec_pc_seq <= camd_pkg::RESET_PC;
    end else if (state == ST_CALC) begin
      dec_opcode <= opcode;
      dec_mode <= c_mode;
      dec_class <= c_cls;
      dec_len <= c_len;
      dec_imm <= (c_mode == camd_pkg::MODE_IMM) ? b1 : 8'h00; // RULE2
      dec_bitnum <= c_bitnum;
      dec_bit_on_set <= c_on_set;
      dec_writeback <= c_wb; // RULE11
      dec_reg_x <= c_reg_x; // RULE12
      dec_carry_load <= (c_cls == camd_pkg::CLS_BITTEST); // RULE9
      dec_pc_seq <= pc;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_inh_one_byte: assert property (dec_valid && dec_mode == camd_pkg::MODE_INH |-> // RULE1
    dec_len == camd_pkg::LEN_1 && dec_ea == 16'h0000) else $error("inherent decode wrong");
  a_imm_operand_byte: assert property (dec_valid && dec_mode == camd_pkg::MODE_IMM |-> // RULE2
    dec_len == camd_pkg::LEN_2 && dec_imm == b1) else $error("immediate operand wrong");
  a_dir_page_zero: assert property (dec_valid && dec_mode == camd_pkg::MODE_DIR |-> // RULE3
    dec_ea == {camd_pkg::PAGE_ZERO, b1}) else $error("direct address wrong");
  a_ext_full_addr: assert property (dec_valid && dec_mode == camd_pkg::MODE_EXT |-> // RULE4
    dec_ea == {b1, b2} && dec_len == camd_pkg::LEN_3) else $error("extended address wrong");
  a_ix_page_zero: assert property (dec_valid && dec_mode == camd_pkg::MODE_IX |-> // RULE5
    dec_ea[15:8] == camd_pkg::PAGE_ZERO) else $error("indexed high byte not zero");
  a_ix1_no_wrap: assert property (dec_valid && dec_mode == camd_pkg::MODE_IX1 |-> // RULE6
    dec_ea <= camd_pkg::IX1_TOP && dec_ea >= {8'h00, b1}) else $error("index sum wrapped");
  a_ix2_sum: assert property (dec_valid && dec_mode == camd_pkg::MODE_IX2 |-> // RULE7
    dec_ea - {b1, b2} <= 16'h00FF) else $error("indexed 16-bit sum wrong");
  a_rel_target: assert property (dec_valid && dec_class == camd_pkg::CLS_BRANCH |-> // RULE8
    pc_next == (dec_taken ? dec_pc_seq + {{8{b1[7]}}, b1} : dec_pc_seq))
    else $error("branch destination wrong");
  a_bit_carry: assert property (dec_valid && dec_class == camd_pkg::CLS_BITTEST // RULE9 RULE10
    |-> dec_carry_load && dec_len == camd_pkg::LEN_3 &&
    dec_taken == (dec_carry_value == dec_bit_on_set)) else $error("bit test result wrong");
  a_tst_no_write: assert property (dec_valid && dec_class == camd_pkg::CLS_RMW |-> // RULE11
    dec_writeback == (dec_opcode[3:0] != camd_pkg::NIB_TST)) else $error("write-back flag wrong");
  a_pc_past_instr: assert property (dec_valid |-> // RULE16
    dec_pc_seq == op_addr + {14'h0000, dec_len}) else $error("pc not past instruction");
  a_valid_one_cycle: assert property (dec_valid |=> !dec_valid [*2]) // RULE13
    else $error("decode valid held");
  a_fetch_in_order: assert property (mem_rd && !opnd_phase && idx != 2'h0 |-> // RULE16
    mem_addr == op_addr + {14'h0000, idx}) else $error("operand fetch out of order");

  c_taken_branch: cover property (dec_valid && dec_class == camd_pkg::CLS_BRANCH && dec_taken);
  c_bit_test: cover property (dec_valid && dec_class == camd_pkg::CLS_BITTEST);
  c_ix2_access: cover property (dec_valid && dec_mode == camd_pkg::MODE_IX2);
  c_rmw_write: cover property (dec_valid && dec_class == camd_pkg::CLS_RMW && dec_writeback);
endmodule : camd_decode
`default_nettype wire

// ### camd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module camd_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr;
  logic [7:0] last = 8'h00;
  int lat = 1;
  int cnt = 0;
  initial begin
    mem_rvalid = 1'b0;
    mem_rdata = 8'hFF;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
  end
  // Answer after lat cycles; between answers the data lines show the inverse
  always @(posedge clk) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~last;
    if (!resetn) begin
      cnt <= 0;
    end else if (mem_rd) begin
      addr <= mem_addr;
      cnt <= lat;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= mem[addr];
      last <= mem[addr];
      cnt <= 0;
    end
  end
endmodule : camd_mem_model
`default_nettype wire

// ### camd_decode_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module camd_decode_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] mem_rdata;
  logic mem_rvalid;
  logic [7:0] index_reg = 8'h00;
  logic ccr_h = 1'b0;
  logic ccr_i = 1'b0;
  logic ccr_n = 1'b0;
  logic ccr_z = 1'b0;
  logic ccr_c = 1'b0;
  logic irq_pin_level = 1'b0;
  logic exec_done = 1'b0;
  logic exec_pc_load = 1'b0;
  logic [15:0] exec_pc_value = 16'h0000;
  logic mem_rd, dec_valid, dec_bit_on_set, dec_writeback, dec_reg_x;
  logic dec_taken, dec_carry_load, dec_carry_value;
  logic [15:0] mem_addr, dec_ea, dec_pc_seq, pc_next;
  logic [7:0] dec_opcode, dec_imm;
  logic [2:0] dec_bitnum;
  logic [1:0] dec_len;
  camd_pkg::camd_mode_t dec_mode;
  camd_pkg::camd_class_t dec_class;
  int fail_count = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  camd_decode camd_decode_inst (.clk(clk), .resetn(resetn), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .index_reg(index_reg), .ccr_h(ccr_h), .ccr_i(ccr_i),
    .ccr_n(ccr_n), .ccr_z(ccr_z), .ccr_c(ccr_c), .irq_pin_level(irq_pin_level),
    .exec_done(exec_done), .exec_pc_load(exec_pc_load), .exec_pc_value(exec_pc_value),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
    .dec_mode(dec_mode), .dec_class(dec_class), .dec_len(dec_len), .dec_ea(dec_ea),
    .dec_imm(dec_imm), .dec_bitnum(dec_bitnum), .dec_bit_on_set(dec_bit_on_set),
    .dec_writeback(dec_writeback), .dec_reg_x(dec_reg_x), .dec_taken(dec_taken),
    .dec_carry_load(dec_carry_load), .dec_carry_value(dec_carry_value),
    .dec_pc_seq(dec_pc_seq), .pc_next(pc_next));
  camd_mem_model camd_mem_model_inst (.clk(clk), .resetn(resetn), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wt;
    int n;
    n = 0;
    while (dec_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CK("dec_valid", 1'b1, dec_valid)
  endtask : wt
  // Place an instruction at p, finish the previous one with a jump to p
  task automatic dec(input logic [15:0] p, input logic [7:0] b0, b1, b2);
    camd_mem_model_inst.mem[p] = b0;
    camd_mem_model_inst.mem[p + 16'h0001] = b1;
    camd_mem_model_inst.mem[p + 16'h0002] = b2;
    exec_done = 1'b1;
    exec_pc_load = 1'b1;
    exec_pc_value = p;
    @(negedge clk);
    exec_done = 1'b0;
    exec_pc_load = 1'b0;
    wt();
  endtask : dec
  task automatic ck(input camd_pkg::camd_mode_t m, input logic [1:0] l,
      input logic [15:0] pn);
    `CK("mode", m, dec_mode)
    `CK("len", l, dec_len)
    `CK("pc_next", pn, pc_next)
  endtask : ck
  task automatic br(input logic [15:0] p, input logic [7:0] op, input logic tk);
    dec(p, op, 8'h10, 8'h00);
    `CK("taken", tk, dec_taken)
    ck(camd_pkg::MODE_REL, 2'h2, tk ? p + 16'h0012 : p + 16'h0002);
  endtask : br
  task automatic t_inh;
    wt();
    ck(camd_pkg::MODE_INH, 2'h1, 16'h0001);
    `CK("class", camd_pkg::CLS_CONTROL, dec_class)
    dec(16'h0010, 8'h4C, 8'h00, 8'h00);
    ck(camd_pkg::MODE_INH, 2'h1, 16'h0011);
    `CK("wb", 1'b1, dec_writeback)
    `CK("opcode", 8'h4C, dec_opcode)
  endtask : t_inh
  task automatic t_imm_dir_ext;
    dec(16'h0100, 8'hA6, 8'h55, 8'h00);
    ck(camd_pkg::MODE_IMM, 2'h2, 16'h0102);
    `CK("imm", 8'h55, dec_imm)
    `CK("reg_x", 1'b0, dec_reg_x)
    `CK("class", camd_pkg::CLS_REGMEM, dec_class)
    dec(16'h0110, 8'hAE, 8'h07, 8'h00);
    `CK("reg_x", 1'b1, dec_reg_x)
    dec(16'h0120, 8'hB6, 8'h80, 8'h00);
    ck(camd_pkg::MODE_DIR, 2'h2, 16'h0122);
    `CK("ea", 16'h0080, dec_ea)
    camd_mem_model_inst.lat = 4;
    dec(16'h0130, 8'hC6, 8'h12, 8'h34);
    camd_mem_model_inst.lat = 1;
    ck(camd_pkg::MODE_EXT, 2'h3, 16'h0133);
    `CK("ea", 16'h1234, dec_ea)
    `CK("mem_addr", 16'h0132, mem_addr)
  endtask : t_imm_dir_ext
  task automatic t_idx;
    index_reg = 8'hF0;
    dec(16'h0140, 8'hF6, 8'h00, 8'h00);
    ck(camd_pkg::MODE_IX, 2'h1, 16'h0141);
    `CK("ea", 16'h00F0, dec_ea)
    index_reg = 8'hFF;
    dec(16'h0150, 8'hE6, 8'hFF, 8'h00);
    ck(camd_pkg::MODE_IX1, 2'h2, 16'h0152);
    `CK("ea", 16'h01FE, dec_ea)
    index_reg = 8'h20;
    dec(16'h0160, 8'hD6, 8'h12, 8'hF0);
    ck(camd_pkg::MODE_IX2, 2'h3, 16'h0163);
    `CK("ea", 16'h1310, dec_ea)
  endtask : t_idx
  task automatic t_rel;
    dec(16'h0200, 8'h20, 8'h80, 8'h00);
    ck(camd_pkg::MODE_REL, 2'h2, 16'h0182);
    `CK("pc_seq", 16'h0202, dec_pc_seq)
    `CK("class", camd_pkg::CLS_BRANCH, dec_class)
    br(16'h0210, 8'h21, 1'b0);
    br(16'h0220, 8'h2E, 1'b1);
    br(16'h0230, 8'h2F, 1'b0);
    irq_pin_level = 1'b1;
    br(16'h0240, 8'h2F, 1'b1);
    br(16'h0250, 8'h2E, 1'b0);
    br(16'h0260, 8'h2C, 1'b1);
    br(16'h0270, 8'h2D, 1'b0);
    ccr_i = 1'b1;
    ccr_h = 1'b1;
    br(16'h0280, 8'h2D, 1'b1);
    br(16'h0290, 8'h28, 1'b0);
    br(16'h02A0, 8'h29, 1'b1);
    br(16'h02C0, 8'h22, 1'b1);
    br(16'h02D0, 8'h25, 1'b0);
    br(16'h02E0, 8'h27, 1'b0);
    br(16'h02F0, 8'h2B, 1'b0);
    dec(16'h02B0, 8'hAD, 8'h04, 8'h00);
    ck(camd_pkg::MODE_REL, 2'h2, 16'h02B6);
  endtask : t_rel
  task automatic t_bit;
    camd_mem_model_inst.mem[16'h0040] = 8'h08;
    dec(16'h0300, 8'h07, 8'h40, 8'h10);
    ck(camd_pkg::MODE_DIR, 2'h3, 16'h0303);
    `CK("bitnum", 3'h3, dec_bitnum)
    `CK("on_set", 1'b0, dec_bit_on_set)
    `CK("c_load", 1'b1, dec_carry_load)
    `CK("c_val", 1'b1, dec_carry_value)
    `CK("ea", 16'h0040, dec_ea)
    `CK("class", camd_pkg::CLS_BITTEST, dec_class)
    `CK("mem_addr", 16'h0040, mem_addr)
    dec(16'h0310, 8'h06, 8'h40, 8'hF0);
    ck(camd_pkg::MODE_DIR, 2'h3, 16'h0303);
    dec(16'h0320, 8'h0F, 8'h40, 8'h02);
    `CK("bitnum", 3'h7, dec_bitnum)
    `CK("c_val", 1'b0, dec_carry_value)
    `CK("pc_next", 16'h0325, pc_next)
  endtask : t_bit
  task automatic t_rmw_jmp;
    dec(16'h0330, 8'h3D, 8'h40, 8'h00);
    `CK("wb", 1'b0, dec_writeback)
    `CK("class", camd_pkg::CLS_RMW, dec_class)
    dec(16'h0340, 8'h3C, 8'h40, 8'h00);
    `CK("wb", 1'b1, dec_writeback)
    dec(16'h0350, 8'hCC, 8'h12, 8'h34);
    `CK("class", camd_pkg::CLS_JUMP, dec_class)
    `CK("ea", 16'h1234, dec_ea)
    dec(16'h0360, 8'h11, 8'h40, 8'h00);
    ck(camd_pkg::MODE_DIR, 2'h2, 16'h0362);
    `CK("class", camd_pkg::CLS_BITMANIP, dec_class)
    `CK("wb", 1'b1, dec_writeback)
    `CK("ea", 16'h0040, dec_ea)
    dec(16'h0370, 8'h5C, 8'h00, 8'h00);
    ck(camd_pkg::MODE_INH, 2'h1, 16'h0371);
    `CK("reg_x", 1'b1, dec_reg_x)
    `CK("class", camd_pkg::CLS_RMW, dec_class)
    dec(16'h0380, 8'h6D, 8'h05, 8'h00);
    ck(camd_pkg::MODE_IX1, 2'h2, 16'h0382);
    `CK("ea", 16'h0025, dec_ea)
    `CK("wb", 1'b0, dec_writeback)
    dec(16'h0390, 8'hBD, 8'h77, 8'h00);
    ck(camd_pkg::MODE_DIR, 2'h2, 16'h0392);
    `CK("class", camd_pkg::CLS_JUMP, dec_class)
    `CK("ea", 16'h0077, dec_ea)
    `CK("reg_x", 1'b0, dec_reg_x)
  endtask : t_rmw_jmp
  task automatic t_reset;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    `CK("rst_rd", 1'b0, mem_rd)
    `CK("rst_addr", camd_pkg::RESET_PC, mem_addr)
    `CK("rst_valid", 1'b0, dec_valid)
    `CK("rst_pc", camd_pkg::RESET_PC, pc_next)
    resetn = 1'b1;
    wt();
    ck(camd_pkg::MODE_INH, 2'h1, 16'h0001);
    `CK("opcode", 8'h9D, dec_opcode)
  endtask : t_reset
  initial begin
    repeat (2) @(negedge clk);
    camd_mem_model_inst.mem[16'h0000] = 8'h9D;
    repeat (18) @(negedge clk);
    resetn = 1'b1;
    t_inh();
    t_imm_dir_ext();
    t_idx();
    t_rel();
    t_bit();
    t_rmw_jmp();
    t_reset();
    give_verdict();
  end
  initial begin
    #3000000;
    fail_count++;
    give_verdict();
  end
endmodule : camd_decode_tb
`default_nettype wire
